// >>> tmr_dual_timer.v
// top of the dual timer/counter with external interrupt detectors and apb register slave
`timescale 1ns/1ns
`include "tmr_map.vh"
module tmr_dual_timer (
    input wire pclk,
    input wire presetn,
    input wire pce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire ext_irq0_pin,
    input wire ext_irq1_pin,
    input wire t0_count_pin,
    input wire t1_count_pin,
    input wire t0_irq_ack,
    input wire t1_irq_ack,
    input wire ext_irq0_ack,
    input wire ext_irq1_ack,
    input wire idle_wake,
    output wire irq,
    output reg t0_overflow_flag,
    output reg t1_overflow_flag,
    output wire ext_irq0_detect,
    output wire ext_irq1_detect,
    output reg timers_frozen,
    output wire t2_prescale_select
);
    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function count_allowed;
        input run;
        input gate;
        input pin;
        begin
            count_allowed = run & (~gate | pin);
        end
    endfunction

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg t0_run;
    reg t1_run;
    reg ext_irq0_type;
    reg ext_irq1_type;
    reg [7:0] timer_mode_select;
    reg [5:0] presc_bits;
    reg smod;
    reg gf1;
    reg gf0;
    reg [3:0] irq_status;
    reg [3:0] irq_enable;
    reg [3:0] sync1;
    reg [3:0] sync2;
    reg [1:0] cnt_prev;
    reg [7:0] rd_val;
    reg rd_hit;
    wire [7:0] timer0_count_low;
    wire [7:0] timer0_count_high;
    wire [7:0] timer1_count_low;
    wire [7:0] timer1_count_high;
    wire t0_ov;
    wire t1_ov;
    wire ext0_edge;
    wire ext1_edge;
    wire [9:0] idx = paddr[11:2];
    wire setup = psel & ~penable;
    wire access = psel & penable & pce;
    wire wr = access & pwrite & rd_hit;
    wire [7:0] wbyte = pwdata[7:0];
    wire w_pwr = wr & (idx == `TMR_IDX_POWER);
    wire w_ctl = wr & (idx == `TMR_IDX_CTRL);
    wire w_mod = wr & (idx == `TMR_IDX_MODE);
    wire w_lo0 = wr & (idx == `TMR_IDX_LO0);
    wire w_lo1 = wr & (idx == `TMR_IDX_LO1);
    wire w_hi0 = wr & (idx == `TMR_IDX_HI0);
    wire w_hi1 = wr & (idx == `TMR_IDX_HI1);
    wire w_presc = wr & (idx == `TMR_IDX_PRESC);
    wire w_iclr = wr & (idx == `TMR_IDX_ICLR);
    wire w_ien = wr & (idx == `TMR_IDX_IEN);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // order: 0 ext_irq0, 1 ext_irq1, 2 t0_count, 3 t1_count
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1 <= 4'hF;
            sync2 <= 4'hF;
            cnt_prev <= 2'h3;
        end
        else if (pce)
        begin
            sync1 <= {t1_count_pin, t0_count_pin, ext_irq1_pin, ext_irq0_pin};
            sync2 <= sync1;
            cnt_prev <= sync2[3:2];
        end
    end

    // counter mode takes one count per falling edge on the count pin
    wire [1:0] cnt_fall = cnt_prev & ~sync2[3:2];

    // ----------------------------------------------------------------
    // idle control
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            timers_frozen <= 1'b0;
        else if (pce)
        begin
            if (idle_wake)
                timers_frozen <= 1'b0;
            else if (w_pwr && wbyte[`TMR_IDLE])
                timers_frozen <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            t0_run <= 1'b0;
            t1_run <= 1'b0;
            ext_irq0_type <= 1'b0;
            ext_irq1_type <= 1'b0;
            timer_mode_select <= `TMR_MODE_RST;
            presc_bits <= 6'h01;
            smod <= 1'b0;
            gf1 <= 1'b0;
            gf0 <= 1'b0;
            irq_enable <= 4'h0;
        end
        else if (pce)
        begin
            if (w_ctl)
            begin
                t0_run <= wbyte[`TMR_RUN0];
                t1_run <= wbyte[`TMR_RUN1];
                ext_irq0_type <= wbyte[`TMR_XT0];
                ext_irq1_type <= wbyte[`TMR_XT1];
            end
            if (w_mod)
                timer_mode_select <= wbyte;
            if (w_presc)
                presc_bits <= wbyte[5:0];
            if (w_pwr)
            begin
                smod <= wbyte[`TMR_SMOD];
                gf1 <= wbyte[`TMR_GF1];
                gf0 <= wbyte[`TMR_GF0];
            end
            if (w_ien)
                irq_enable <= wbyte[3:0];
        end
    end

    // ----------------------------------------------------------------
    // overflow flags
    // ----------------------------------------------------------------
    // a new overflow wins over a clear in the same cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            t0_overflow_flag <= 1'b0;
            t1_overflow_flag <= 1'b0;
        end
        else if (pce)
        begin
            if (t0_ov)
                t0_overflow_flag <= 1'b1;
            else if (w_ctl)
                t0_overflow_flag <= wbyte[`TMR_OV0];
            else if (t0_irq_ack)
                t0_overflow_flag <= 1'b0;
            if (t1_ov)
                t1_overflow_flag <= 1'b1;
            else if (w_ctl)
                t1_overflow_flag <= wbyte[`TMR_OV1];
            else if (t1_irq_ack)
                t1_overflow_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status
    // ----------------------------------------------------------------
    wire [3:0] events = {ext1_edge, ext0_edge, t1_ov, t0_ov};
    wire [3:0] clr_mask = w_iclr ? wbyte[3:0] : 4'h0;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_status <= 4'h0;
        else if (pce)
            irq_status <= (irq_status & ~clr_mask) | events;
    end

    assign irq = |(irq_status & irq_enable);

    // ----------------------------------------------------------------
    // timer channels
    // ----------------------------------------------------------------
    wire t0_en = count_allowed(t0_run, timer_mode_select[`TMR_T0_GATE], sync2[0]);
    // mode 11 stops timer 1; its count stays readable and writable
    wire t1_en = count_allowed(t1_run, timer_mode_select[`TMR_T1_GATE], sync2[1])
        & (timer_mode_select[5:4] != `TMR_MODE_HALT);

    tmr_counter u_timer0 (
        .clk(pclk),
        .rst_n(presetn),
        .ce(pce),
        .freeze(timers_frozen),
        .enable(t0_en),
        .ext_mode(timer_mode_select[`TMR_T0_CT]),
        .ext_tick(cnt_fall[0]),
        .fast(presc_bits[`TMR_T0F]),
        .mode(timer_mode_select[1:0]),
        .wr_low(w_lo0),
        .wr_high(w_hi0),
        .wdata(wbyte),
        .count_low(timer0_count_low),
        .count_high(timer0_count_high),
        .overflow(t0_ov)
    );

    tmr_counter u_timer1 (
        .clk(pclk),
        .rst_n(presetn),
        .ce(pce),
        .freeze(timers_frozen),
        .enable(t1_en),
        .ext_mode(timer_mode_select[`TMR_T1_CT]),
        .ext_tick(cnt_fall[1]),
        .fast(presc_bits[`TMR_T1F]),
        .mode(timer_mode_select[5:4]),
        .wr_low(w_lo1),
        .wr_high(w_hi1),
        .wdata(wbyte),
        .count_low(timer1_count_low),
        .count_high(timer1_count_high),
        .overflow(t1_ov)
    );

    // timer 2 lives elsewhere; it ignores this bit in baud and clock-out use
    assign t2_prescale_select = presc_bits[`TMR_T2F];

    // ----------------------------------------------------------------
    // external interrupt detectors
    // ----------------------------------------------------------------
    tmr_extint u_ext0 (
        .clk(pclk),
        .rst_n(presetn),
        .ce(pce),
        .pin(sync2[0]),
        .edge_sel(ext_irq0_type),
        .sw_wr(w_ctl),
        .sw_val(wbyte[`TMR_XD0]),
        .ack(ext_irq0_ack),
        .detect(ext_irq0_detect),
        .edge_event(ext0_edge)
    );

    tmr_extint u_ext1 (
        .clk(pclk),
        .rst_n(presetn),
        .ce(pce),
        .pin(sync2[1]),
        .edge_sel(ext_irq1_type),
        .sw_wr(w_ctl),
        .sw_val(wbyte[`TMR_XD1]),
        .ack(ext_irq1_ack),
        .detect(ext_irq1_detect),
        .edge_event(ext1_edge)
    );

    // ----------------------------------------------------------------
    // register read decode
    // ----------------------------------------------------------------
    always @*
    begin
        rd_hit = 1'b1;
        rd_val = 8'h00;
        case (idx)
            `TMR_IDX_POWER:
                rd_val = {smod, 3'b011, gf1, gf0, 2'b00};
            `TMR_IDX_CTRL:
                rd_val = {t1_overflow_flag, t1_run, t0_overflow_flag, t0_run,
                    ext_irq1_detect, ext_irq1_type, ext_irq0_detect, ext_irq0_type};
            `TMR_IDX_MODE:
                rd_val = timer_mode_select;
            `TMR_IDX_LO0:
                rd_val = timer0_count_low;
            `TMR_IDX_LO1:
                rd_val = timer1_count_low;
            `TMR_IDX_HI0:
                rd_val = timer0_count_high;
            `TMR_IDX_HI1:
                rd_val = timer1_count_high;
            `TMR_IDX_PRESC:
                rd_val = {2'b00, presc_bits};
            `TMR_IDX_ISTAT:
                rd_val = {4'h0, irq_status};
            `TMR_IDX_ICLR:
                rd_val = 8'h00;
            `TMR_IDX_IEN:
                rd_val = {4'h0, irq_enable};
            default:
                rd_hit = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // apb response
    // ----------------------------------------------------------------
    // read data is taken in the setup cycle so it comes from a flop
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (pce && setup)
            prdata <= {24'h000000, rd_val};
    end

    // no wait states while enabled; held clock enable stretches the access
    assign pready = pce;
    assign pslverr = psel & penable & ~rd_hit;

endmodule // tmr_dual_timer

// >>> tmr_map.vh
// register map, field positions, reset values and timing counts of the dual timer block
// Function
// - overflow flag sets on pass of mode maximum; software or vector acknowledge clears it
// - timer counts only while its run bit is 1; clearing it holds both bytes
// - gate 0 ignores the interrupt pin; gate 1 counts only while that pin is high
// - source select 0 counts prescaled clock; 1 counts pulses on the count pin
// - mode 00 is 8-bit counter behind 5-bit prescale; mode 01 is 16-bit counter
// - mode 10 is an 8-bit counter that reloads itself on overflow
// - mode 11 stops timer 1 and keeps its count
// - mode register holds timer 1 fields in upper nibble, timer 0 in lower
// - interrupt type bit selects level detection at 0, edge detection at 1
// - edge mode sets detect flag on edge; stays until software clear or vector
// - level mode detect flag shows the inverse of the pin level
// - timer 1 and timer 2 select bits pick crystal divided by 12 or 4
// - timer 2 select bit is ignored in baud-rate or clock-output use
// - prescale selects change only timer count rate, not instruction timing
// - idle freezes timers 0, 1 and 2; idle bit always reads 0
// - each count is a separately addressed low byte and high byte
// - timer 0 select bit picks crystal divided by 12 or 4
`ifndef TMR_MAP_VH
`define TMR_MAP_VH

// register indices; byte address is four times the index
`define TMR_IDX_POWER 10'h087
`define TMR_IDX_CTRL 10'h088
`define TMR_IDX_MODE 10'h089
`define TMR_IDX_LO0 10'h08A
`define TMR_IDX_LO1 10'h08B
`define TMR_IDX_HI0 10'h08C
`define TMR_IDX_HI1 10'h08D
`define TMR_IDX_PRESC 10'h08E
`define TMR_IDX_ISTAT 10'h0F0
`define TMR_IDX_ICLR 10'h0F1
`define TMR_IDX_IEN 10'h0F2

// timer_control_flags fields
`define TMR_OV1 7
`define TMR_RUN1 6
`define TMR_OV0 5
`define TMR_RUN0 4
`define TMR_XD1 3
`define TMR_XT1 2
`define TMR_XD0 1
`define TMR_XT0 0

// timer_mode_select fields
`define TMR_T1_GATE 7
`define TMR_T1_CT 6
`define TMR_T1_MODE_HI 5
`define TMR_T1_MODE_LO 4
`define TMR_T0_GATE 3
`define TMR_T0_CT 2
`define TMR_T0_MODE_HI 1
`define TMR_T0_MODE_LO 0

// timer_clock_prescale fields
`define TMR_T2F 5
`define TMR_T1F 4
`define TMR_T0F 3

// power_control fields
`define TMR_SMOD 7
`define TMR_GF1 3
`define TMR_GF0 2
`define TMR_IDLE 0

// reset values
`define TMR_CTRL_RST 8'h00
`define TMR_MODE_RST 8'h00
`define TMR_COUNT_RST 8'h00
`define TMR_PRESC_RST 8'h01
`define TMR_POWER_RST 8'h30

// operating modes
`define TMR_MODE_PRE 2'b00
`define TMR_MODE_16 2'b01
`define TMR_MODE_RELOAD 2'b10
`define TMR_MODE_HALT 2'b11

// crystal divisors
`define TMR_DIV_SLOW 4'hC
`define TMR_DIV_FAST 4'h4

`endif

// >>> tmr_extint.v
// external interrupt level or edge detector
`timescale 1ns/1ns
module tmr_extint (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire pin,
    input wire edge_sel,
    input wire sw_wr,
    input wire sw_val,
    input wire ack,
    output wire detect,
    output reg edge_event
);
    reg prev;
    reg flag;
    // pin is active low: a falling edge is the request
    wire fall = prev & ~pin;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev <= 1'b1;
            flag <= 1'b0;
            edge_event <= 1'b0;
        end
        else if (ce)
        begin
            prev <= pin;
            edge_event <= edge_sel & fall;
            if (!edge_sel)
                flag <= 1'b0;
            else if (fall)
                flag <= 1'b1;
            else if (sw_wr)
                flag <= sw_val;
            else if (ack)
                flag <= 1'b0;
        end
    end

    assign detect = edge_sel ? flag : ~pin;
endmodule // tmr_extint

// >>> tmr_counter.v
// one timer/counter channel with its own prescaler and four modes
`timescale 1ns/1ns
`include "tmr_map.vh"
module tmr_counter (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire freeze,
    input wire enable,
    input wire ext_mode,
    input wire ext_tick,
    input wire fast,
    input wire [1:0] mode,
    input wire wr_low,
    input wire wr_high,
    input wire [7:0] wdata,
    output reg [7:0] count_low,
    output reg [7:0] count_high,
    output reg overflow
);
    reg [3:0] pre;
    // own divider per channel, so the cpu cycle is never touched
    wire [3:0] pre_last = fast ? (`TMR_DIV_FAST - 4'h1) : (`TMR_DIV_SLOW - 4'h1);
    wire pre_tick = (pre >= pre_last);
    wire tick = enable & (ext_mode ? ext_tick : pre_tick);

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pre <= 4'h0;
        else if (ce && !freeze)
            pre <= pre_tick ? 4'h0 : pre + 4'h1;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_low <= `TMR_COUNT_RST;
            count_high <= `TMR_COUNT_RST;
            overflow <= 1'b0;
        end
        else if (ce)
        begin
            overflow <= 1'b0;
            if (wr_low)
                count_low <= wdata;
            if (wr_high)
                count_high <= wdata;
            // a software write wins over a count in the same cycle
            if (!freeze && tick && !wr_low && !wr_high)
            begin
                case (mode)
                    `TMR_MODE_PRE:
                    begin
                        if (&count_low[4:0])
                        begin
                            count_low[4:0] <= 5'h00;
                            count_high <= count_high + 8'h01;
                            overflow <= &count_high;
                        end
                        else
                            count_low[4:0] <= count_low[4:0] + 5'h01;
                    end
                    `TMR_MODE_16:
                    begin
                        count_low <= count_low + 8'h01;
                        if (&count_low)
                        begin
                            count_high <= count_high + 8'h01;
                            overflow <= &count_high;
                        end
                    end
                    `TMR_MODE_RELOAD:
                    begin
                        if (&count_low)
                        begin
                            count_low <= count_high;
                            overflow <= 1'b1;
                        end
                        else
                            count_low <= count_low + 8'h01;
                    end
                    default:
                    begin
                        count_low <= count_low;
                    end
                endcase
            end
        end
    end
endmodule // tmr_counter

// >>> tmr_dual_timer_chk.sv
// assertion checker bound to the dual timer top
`timescale 1ns/1ns
`include "tmr_map.vh"
module tmr_dual_timer_chk (
    input wire pclk,
    input wire presetn,
    input wire pce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire ext_irq0_pin,
    input wire t0_irq_ack,
    input wire ext_irq0_ack,
    input wire t0_overflow_flag,
    input wire ext_irq0_detect,
    input wire timers_frozen,
    input wire t2_prescale_select
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
// ----------------------------------------
// shadow of control bits written over apb
// ----------------------------------------
wire wr = psel && penable && pwrite && pce;
wire ctl_wr = wr && paddr[11:2] == `TMR_IDX_CTRL;
wire ck_wr = wr && paddr[11:2] == `TMR_IDX_PRESC;
wire rd_pc = psel && penable && !pwrite && paddr[11:2] == `TMR_IDX_POWER;
reg [1:0] ctl;
reg [1:0] dly;
// quiet needs two cycles: an overflow launched on the stop edge still lands one edge later
wire quiet = !ctl[1] && !dly[1] && !ctl_wr;
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ctl <= 2'h0;
        dly <= 2'h0;
    end
    else
    begin
        if (ctl_wr)
            ctl <= {pwdata[`TMR_RUN0], pwdata[`TMR_XT0]};
        dly <= {ctl[1], timers_frozen};
    end
end
property p_ack_clears;
    t0_irq_ack && pce && quiet |=> !t0_overflow_flag;
endproperty
a_ack_clears: assert property (p_ack_clears) else $error("ack left overflow flag set");
property p_halt_holds;
    quiet && !t0_overflow_flag |=> !t0_overflow_flag;
endproperty
a_halt_holds: assert property (p_halt_holds) else $error("halted timer raised its flag");
property p_edge_sets;
    ctl[0] && pce && $fell(ext_irq0_pin) |-> ##[1:4] ext_irq0_detect;
endproperty
a_edge_sets: assert property (p_edge_sets) else $error("falling edge not detected");
property p_edge_sticks;
    ctl[0] && ext_irq0_detect && !ext_irq0_ack && !ctl_wr |=> ext_irq0_detect;
endproperty
a_edge_sticks: assert property (p_edge_sticks) else $error("edge flag dropped by itself");
property p_level_follows;
    (!ctl[0] && pce && $stable(ext_irq0_pin))[*3] |-> ext_irq0_detect == !ext_irq0_pin;
endproperty
a_level_follows: assert property (p_level_follows) else $error("level flag not inverse of pin");
property p_t2_select;
    ck_wr |=> t2_prescale_select == $past(pwdata[`TMR_T2F]);
endproperty
a_t2_select: assert property (p_t2_select) else $error("timer 2 select not stored");
property p_idle_freezes;
    timers_frozen && dly[0] && !ctl_wr && !t0_overflow_flag |=> !t0_overflow_flag;
endproperty
a_idle_freezes: assert property (p_idle_freezes) else $error("frozen timer raised its flag");
property p_idle_reads0;
    rd_pc && pce |-> prdata[`TMR_IDLE] == 1'h0;
endproperty
a_idle_reads0: assert property (p_idle_reads0) else $error("idle bit read back as one");
endmodule // tmr_dual_timer_chk

bind tmr_dual_timer tmr_dual_timer_chk chk (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .ext_irq0_pin(ext_irq0_pin), .t0_irq_ack(t0_irq_ack), .ext_irq0_ack(ext_irq0_ack),
    .t0_overflow_flag(t0_overflow_flag), .ext_irq0_detect(ext_irq0_detect),
    .timers_frozen(timers_frozen), .t2_prescale_select(t2_prescale_select));

// >>> tmr_pins.sv
// far-side pin model: interrupt pin levels and count pulses
`timescale 1ns/1ns
module tmr_pins (
    input wire clk,
    input wire [1:0] irq_lvl,
    input wire [1:0] pulse_req,
    output reg [1:0] irq_pin,
    output reg [1:0] cnt_pin
);
// ------------------
// pin drivers
// ------------------
reg [3:0] ph [0:1];
integer i;
initial
begin
    ph[0] = 4'h0;
    ph[1] = 4'h0;
    irq_pin = 2'h3;
    cnt_pin = 2'h3;
end
always @(posedge clk)
begin
    irq_pin <= irq_lvl;
    for (i = 0; i < 2; i = i + 1)
    begin
        if (ph[i] != 4'h0)
            ph[i] <= ph[i] - 4'h1;
        else if (pulse_req[i])
            ph[i] <= 4'h8;
        // four cycles low then at least five high, long enough for the two-flop synchroniser
        cnt_pin[i] <= ph[i] < 4'h5;
    end
end
endmodule // tmr_pins

// >>> tmr_dual_timer_tb.sv
// self-checking bench for the dual timer block
`timescale 1ns/1ns
`include "tmr_map.vh"
module tmr_dual_timer_tb;
reg pclk, presetn, pce, psel, penable, pwrite, idle_wake, run, en, fl, e;
reg [11:0] paddr;
reg [31:0] pwdata, r;
reg [3:0] ack;
reg [1:0] lvl, req;
reg [7:0] q, tl, th;
wire [31:0] prdata;
wire pready, pslverr, irq, f0, f1, d0, d1, frz, t2s;
wire [1:0] ipin, cpin;
integer miscompares, checks_done, t, m, n, k, ex;
tmr_dual_timer dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq0_pin(ipin[0]), .ext_irq1_pin(ipin[1]), .t0_count_pin(cpin[0]),
    .t1_count_pin(cpin[1]), .t0_irq_ack(ack[0]), .t1_irq_ack(ack[1]), .ext_irq0_ack(ack[2]),
    .ext_irq1_ack(ack[3]), .idle_wake(idle_wake), .irq(irq), .t0_overflow_flag(f0),
    .t1_overflow_flag(f1), .ext_irq0_detect(d0), .ext_irq1_detect(d1), .timers_frozen(frz),
    .t2_prescale_select(t2s));
tmr_pins far (.clk(pclk), .irq_lvl(lvl), .pulse_req(req), .irq_pin(ipin), .cnt_pin(cpin));
// ------------------
// tasks
// ------------------
task chk(input [31:0] seen, input [31:0] exp);
begin
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
end
endtask
task apb(input w, input [9:0] ix, input [7:0] d);
begin
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {ix, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
        @(posedge pclk);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // registers written at the access edge are only settled one edge later
    @(posedge pclk);
end
endtask
task hit(input integer b);
begin
    ack[b] <= 1'h1;
    @(posedge pclk);
    ack <= 4'h0;
    @(posedge pclk);
end
endtask
// software model of one counted event
task step;
begin
    if (m == 0)
    begin
        {th, tl[4:0]} = {th, tl[4:0]} + 13'h1;
        fl = fl | (th == 8'h0 && tl[4:0] == 5'h0);
    end
    if (m == 1)
    begin
        {th, tl} = {th, tl} + 16'h1;
        fl = fl | ({th, tl} == 16'h0);
    end
    if (m == 2)
    begin
        fl = fl | (tl == 8'hFF);
        tl = tl == 8'hFF ? th : tl + 8'h1;
    end
end
endtask
task stop_test;
begin
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
end
endtask
initial
begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
end
initial
begin
    repeat (20000) @(posedge pclk);
    miscompares = miscompares + 1;
    stop_test;
end
// ------------------
// main sequence
// ------------------
initial
begin
    {presetn, psel, penable, pwrite, idle_wake, ack, req, paddr, pwdata} = 0;
    {pce, lvl} = 3'h7;
    miscompares = 0;
    checks_done = 0;
    r = $urandom(54);
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    for (k = 0; k < 8; k = k + 1)
    begin
        apb(0, `TMR_IDX_POWER + k, 8'h0);
        chk(q, k == 0 ? `TMR_POWER_RST : k == 7 ? `TMR_PRESC_RST : 8'h0);
    end
    apb(1, 10'h3FF, 8'hFF);
    chk(e, 1);
    apb(0, 10'h3FF, 8'h0);
    chk({e, q}, 9'h100);
    apb(1, `TMR_IDX_IEN, 8'h03);
    for (k = 0; k < 24; k = k + 1)
    begin
        t = k % 2;
        m = (k / 2) % 4;
        r = $urandom;
        run = r[9] | r[10];
        lvl <= r[12:11];
        en = run & (!r[8] | r[11 + t]);
        tl = {r[7:5], 3'h7, r[1:0]};
        th = m == 2 ? r[23:16] : 8'hFF;
        fl = 1'h0;
        apb(1, `TMR_IDX_MODE, {4'h0, r[8], 1'h1, m[1:0]} << (4 * t));
        apb(1, `TMR_IDX_LO0 + t, tl);
        apb(1, `TMR_IDX_HI0 + t, th);
        apb(1, `TMR_IDX_CTRL, {7'h0, run} << (4 + 2 * t));
        repeat (1 + r[14:13])
        begin
            req[t] <= 1'h1;
            @(posedge pclk);
            req <= 2'h0;
            repeat (12) @(posedge pclk);
            if (en)
                step;
        end
        apb(0, `TMR_IDX_LO0 + t, 8'h0);
        chk(q, tl);
        apb(0, `TMR_IDX_HI0 + t, 8'h0);
        chk(q, th);
        chk(t ? f1 : f0, fl);
        chk(irq, fl);
        chk({d1, d0}, {~lvl});
        apb(1, `TMR_IDX_CTRL, {7'h0, fl} << (5 + 2 * t));
        repeat (2) @(posedge pclk);
        hit(t);
        chk(t ? f1 : f0, 0);
        apb(1, `TMR_IDX_ICLR, 8'h0F);
    end
    for (k = 0; k < 4; k = k + 1)
    begin
        t = k % 2;
        apb(1, `TMR_IDX_MODE, 8'h11);
        apb(1, `TMR_IDX_LO0 + t, 8'h0);
        apb(1, `TMR_IDX_PRESC, (k / 2) * 8'h29 << t);
        chk(t2s, k / 2 * (1 - t));
        apb(1, `TMR_IDX_CTRL, 8'h10 << (2 * t));
        repeat (238) @(posedge pclk);
        apb(1, `TMR_IDX_CTRL, 8'h0);
        apb(0, `TMR_IDX_LO0 + t, 8'h0);
        ex = k / 2 ? 60 : 20;
        chk(q >= ex - 1 && q <= ex + 1, 1);
    end
    lvl <= 2'h3;
    for (t = 0; t < 2; t = t + 1)
    begin
        apb(1, `TMR_IDX_CTRL, 8'h05);
        apb(1, `TMR_IDX_IEN, 8'h0C);
        repeat (2)
        begin
            lvl[t] <= 1'h0;
            repeat (6) @(posedge pclk);
            lvl[t] <= 1'h1;
            repeat (6) @(posedge pclk);
            chk({d1, d0}, 2'h1 << t);
            chk(irq, 1);
            hit(2 + t);
            chk({d1, d0}, 0);
        end
        apb(0, `TMR_IDX_ISTAT, 8'h0);
        chk(q, 8'h04 << t);
        apb(1, `TMR_IDX_IEN, 8'h0);
        chk(irq, 0);
        apb(1, `TMR_IDX_ICLR, 8'h0F);
    end
    apb(1, `TMR_IDX_CTRL, 8'h50);
    apb(1, `TMR_IDX_POWER, 8'h01);
    chk(frz, 1);
    apb(0, `TMR_IDX_LO0, 8'h0);
    tl = q;
    repeat (40) @(posedge pclk);
    apb(0, `TMR_IDX_LO0, 8'h0);
    chk(q, tl);
    apb(0, `TMR_IDX_POWER, 8'h0);
    chk(q, 8'h30);
    idle_wake <= 1'h1;
    @(posedge pclk);
    idle_wake <= 1'h0;
    repeat (40) @(posedge pclk);
    apb(0, `TMR_IDX_LO0, 8'h0);
    chk(q != tl && frz == 1'h0, 1);
    stop_test;
end
endmodule // tmr_dual_timer_tb
